// file: residual_overcurrent_stage_test.sv
`timescale 1ns/1ps
module residual_overcurrent_stage_test;
    localparam int P = 20;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic remote_wr = 1'b0;
    logic block_in = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [19:0] remote_thr = 20'h0;
    logic [19:0] level = 20'h0;
    logic [2:0] group_sel = 3'h0;
    logic [2:0] ch = 3'h0;
    logic [31:0] reg_rdata, evt_stamp, v, w;
    logic [6:0][19:0] mags;
    logic start_out, trip_out, blocked_out, evt_valid;
    logic [2:0] evt_code;
    logic [19:0] evt_mag;
    int n_errors = 0;
    int check_count = 0;
    int thr = 12000;
    int exp_codes[4] = '{0, 2, 1, 3};
    bit picked = 0;
    rostg_stage #(.PROG_CYCLES(P)) uut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .remote_wr(remote_wr), .remote_thr(remote_thr), .coarse_rms(mags[0]),
        .coarse_true_rms_with_harmonics(mags[1]), .coarse_pp(mags[2]), .sens_rms(mags[3]), .sens_true_rms_with_harmonics(mags[4]),
        .sens_pp(mags[5]), .calc_rms(mags[6]), .block_in(block_in), .group_sel(group_sel),
        .start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out),
        .evt_valid(evt_valid), .evt_code(evt_code), .evt_stamp(evt_stamp), .evt_mag(evt_mag));
    rostg_front u_front (.core_clk(core_clk), .level(level), .ch(ch), .mags(mags),
        .evt_valid(evt_valid), .evt_code(evt_code), .evt_stamp(evt_stamp), .evt_mag(evt_mag));
    // ==========================================
    // helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        check(d, exp);
    endtask
    task automatic remote(input logic [19:0] t);
        @(posedge core_clk);
        remote_thr <= t;
        remote_wr <= 1'b1;
        @(posedge core_clk);
        remote_wr <= 1'b0;
    endtask
    // sampling on the falling edge keeps clear of the register updates
    task automatic ticks(input int n);
        repeat (n * P) @(negedge core_clk);
    endtask
    // reference model: pick-up with 97 percent release, blocking diverts to blocked
    task automatic apply(input int lv, input bit b);
        @(posedge core_clk);
        level <= 20'(lv);
        block_in <= b;
        ticks(3);
        if (lv > thr) picked = 1;
        else if (lv * 100 < thr * 97) picked = 0;
        check(start_out, picked && !b);
        check(trip_out, picked && !b);
        check(blocked_out, picked && b);
    endtask
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        #1ms;
        n_errors++;
        end_sim();
    end
    // ==========================================
    // main sequence
    initial begin
        void'($urandom(32'h2f40));
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        rdc(8'h00, 32'h45);
        rdc(8'h40, 32'h2ee0);
        rdc(8'hfc, 32'h0);
        rd(8'h28, v);
        repeat (P - 2) @(posedge core_clk);
        rd(8'h28, w);
        check(w - v, 32'h1);
        $display("test defaults done");
        apply(12000, 1'b0);
        u_front.codes.delete();
        u_front.stamps.delete();
        u_front.levels.delete();
        apply(12001, 1'b0);
        apply(11640, 1'b0);
        apply(11639, 1'b0);
        check(u_front.codes.size(), 32'h4);
        for (int i = 0; i < 4; i++) check(u_front.codes[i], exp_codes[i]);
        check(u_front.stamps[0], u_front.stamps[1]);
        check(u_front.levels[1], 32'h2ee1);
        check(u_front.levels[2], 32'h2d77);
        rdc(8'h08, 32'h1);
        rdc(8'h0c, 32'h1);
        apply(12001, 1'b1);
        apply(0, 1'b0);
        rdc(8'h10, 32'h1);
        rdc(8'h1c, 32'h112);
        rdc(8'h20, 32'h2ee1);
        wr(8'h00, 32'h245);
        rdc(8'h08, 32'h0);
        $display("test pick-up done");
        remote(20'h01388);
        rdc(8'h40, 32'h2ee0);
        wr(8'h00, 32'h85);
        remote(20'h01388);
        rdc(8'h40, 32'h1388);
        thr = 5000;
        wr(8'h48, 32'h1f40);
        wr(8'h4c, 32'hd);
        group_sel <= 3'h1;
        thr = 8000;
        ticks(4);
        rdc(8'h00, 32'h85);
        rdc(8'h04, 32'h20);
        @(posedge core_clk);
        level <= 20'h01f41;
        for (int i = 0; i < 4 * P && start_out !== 1'b1; i++) @(negedge core_clk);
        check(start_out, 32'h1);
        check(trip_out, 32'h0);
        ticks(1);
        check(trip_out, 32'h0);
        ticks(1);
        check(trip_out, 32'h1);
        apply(0, 1'b0);
        @(posedge core_clk);
        group_sel <= 3'h0;
        thr = 5000;
        $display("test groups done");
        // every source and magnitude code; magnitude is ignored on the calculated source
        for (int s = 1; s < 4; s++) begin
            for (int m = 1; m < 4; m++) begin
                wr(8'h00, 32'h80 | (m << 2) | s);
                ch <= (s == 3) ? 3'h6 : 3'((s - 1) * 3 + m - 1);
                apply(thr + 1 + $urandom % 500, 1'b0);
                apply($urandom % 4800, 1'b0);
            end
        end
        $display("test sources done");
        // forcing needs the global enable; normal mode must come back clean
        wr(8'h00, 32'h0a5);
        ticks(2);
        check(trip_out, 32'h0);
        wr(8'h00, 32'h1a5);
        ticks(2);
        check({blocked_out, trip_out, start_out}, 32'h3);
        wr(8'h00, 32'h1b5);
        ticks(2);
        check({blocked_out, trip_out, start_out}, 32'h4);
        wr(8'h00, 32'h085);
        ch <= 3'h0;
        ticks(2);
        check({blocked_out, trip_out, start_out}, 32'h0);
        // a long steady level fills both averaging windows before the fault
        apply(3000, 1'b0);
        ticks(60);
        apply(5100, 1'b0);
        wr(8'h14, 32'h3);
        rdc(8'h24, 32'hbb8);
        rdc(8'h1c, 32'h262);
        $display("test force and history done");
        end_sim();
    end
endmodule

// file: rostg_front.sv
`timescale 1ns/1ps
// ==========================================
// front end model: level on the chosen channel, drifting noise elsewhere
module rostg_front (
    // clock
    input wire logic core_clk,
    // wanted level and channel
    input wire logic [19:0] level,
    input wire logic [2:0] ch,
    // coarse rms/true_rms_with_harmonics/pp, sensitive rms/true_rms_with_harmonics/pp, calculated rms
    output logic [6:0][19:0] mags,
    // event buffer
    input wire logic evt_valid,
    input wire logic [2:0] evt_code,
    input wire logic [31:0] evt_stamp,
    input wire logic [19:0] evt_mag
);
    logic [3:0] noise = 4'h0;
    logic [2:0] codes[$];
    logic [31:0] stamps[$];
    logic [19:0] levels[$];
    // each magnitude kind has its own line; noise keeps idle lines from looking steady
    always @(posedge core_clk) begin
        noise <= noise + 4'h1;
        for (int i = 0; i < 7; i++) begin
            mags[i] <= (i == ch) ? level : {16'h0000, noise};
        end
    end
    // shared event buffer, no back-pressure
    always @(posedge core_clk) begin
        if (evt_valid === 1'b1) begin
            codes.push_back(evt_code);
            stamps.push_back(evt_stamp);
            levels.push_back(evt_mag);
        end
    end
endmodule

// file: rostg_pkg.sv
package rostg_pkg;
    // ==========================================
    // timing
    localparam int CLK_NS = 50;
    localparam int PROG_CYCLE_US = 1000;
    localparam int PROG_CYCLES = PROG_CYCLE_US * 1000 / CLK_NS;
    localparam int AVG_MS = 20;
    // ==========================================
    // sizes
    localparam int GROUPS = 8;
    localparam int HIST_N = 12;
    localparam int MAG_W = 20;
    localparam int RESET_PCT = 97;
    localparam logic [19:0] THR_RST = 20'h02ee0;
    // ==========================================
    // setting encodings
    localparam logic [1:0] SRC_COARSE = 2'h1;
    localparam logic [1:0] SRC_SENS = 2'h2;
    localparam logic [1:0] SRC_CALC = 2'h3;
    localparam logic [1:0] MAG_RMS = 2'h1;
    localparam logic [1:0] MAG_TRUE_RMS_WITH_HARMONICS = 2'h2;
    localparam logic [1:0] MAG_PP = 2'h3;
    localparam logic [1:0] FORCE_NORMAL = 2'h0;
    localparam logic [1:0] FORCE_START = 2'h1;
    localparam logic [1:0] FORCE_TRIP = 2'h2;
    localparam logic [1:0] FORCE_BLOCKED = 2'h3;
    localparam logic [1:0] REMOTE_OFF = 2'h1;
    localparam logic [1:0] REMOTE_ON = 2'h2;
    localparam logic [1:0] DLY_INSTANT = 2'h0;
    localparam logic [1:0] DLY_FIXED = 2'h1;
    localparam logic [1:0] DLY_INVERSE = 2'h2;
    // ==========================================
    // register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CNT_START = 8'h08;
    localparam logic [7:0] REG_CNT_TRIP = 8'h0c;
    localparam logic [7:0] REG_CNT_BLOCK = 8'h10;
    localparam logic [7:0] REG_HIST_SEL = 8'h14;
    localparam logic [7:0] REG_HIST_STAMP = 8'h18;
    localparam logic [7:0] REG_HIST_INFO = 8'h1c;
    localparam logic [7:0] REG_HIST_FAULT = 8'h20;
    localparam logic [7:0] REG_HIST_PRE = 8'h24;
    localparam logic [7:0] REG_TIME = 8'h28;
    localparam logic [1:0] GRP_PAGE = 2'h1;
    // ctrl fields
    localparam int CTRL_SRC = 0;
    localparam int CTRL_MAG = 2;
    localparam int CTRL_FORCE = 4;
    localparam int CTRL_REMOTE = 6;
    localparam int CTRL_FORCE_EN = 8;
    localparam int CTRL_CNT_CLR = 9;
    // event codes
    localparam logic [2:0] EVT_START_ON = 3'h0;
    localparam logic [2:0] EVT_TRIP_ON = 3'h2;
    localparam logic [2:0] EVT_BLOCK_ON = 3'h4;
endpackage

// file: rostg_stage.sv
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module rostg_stage #(
    parameter int PROG_CYCLES = rostg_pkg::PROG_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // supervisory bus threshold write
    input wire logic remote_wr,
    input wire logic [19:0] remote_thr,
    // processed magnitudes from the front end
    input wire logic [19:0] coarse_rms,
    input wire logic [19:0] coarse_true_rms_with_harmonics,
    input wire logic [19:0] coarse_pp,
    input wire logic [19:0] sens_rms,
    input wire logic [19:0] sens_true_rms_with_harmonics,
    input wire logic [19:0] sens_pp,
    input wire logic [19:0] calc_rms,
    // pins
    input wire logic block_in,
    input wire logic [2:0] group_sel,
    // stage outputs
    output logic start_out,
    output logic trip_out,
    output logic blocked_out,
    // event buffer
    output logic evt_valid,
    output logic [2:0] evt_code,
    output logic [31:0] evt_stamp,
    output logic [19:0] evt_mag
);
    // ==========================================
    // synchronisers and program cycle tick
    logic [1:0] blk_sync;
    logic [2:0] grp_s1, grp_s2;
    logic blk_q, tick;
    logic [2:0] grp_q;
    logic [15:0] tick_cnt;
    logic [31:0] ms_count;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            blk_sync <= 2'h0;
            grp_s1 <= 3'h0;
            grp_s2 <= 3'h0;
        end else begin
            blk_sync <= {blk_sync[0], block_in};
            grp_s1 <= group_sel;
            grp_s2 <= grp_s1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tick_cnt <= 16'h0;
            tick <= 1'b0;
        end else begin
            tick <= (tick_cnt == 16'(PROG_CYCLES - 1));
            tick_cnt <= (tick_cnt == 16'(PROG_CYCLES - 1)) ? 16'h0 : tick_cnt + 16'h1;
        end
    end

    // ms stamp advances on every program cycle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ms_count <= 32'h0;
        end else if (tick) begin
            ms_count <= ms_count + 32'h1;
        end
    end

    // block and group are latched at the head of each cycle and held until the next
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            blk_q <= 1'b0;
            grp_q <= 3'h0;
        end else if (tick) begin
            blk_q <= blk_sync[1];
            grp_q <= grp_s2;
        end
    end

    // ==========================================
    // settings
    logic [1:0] src_sel, mag_sel, force_sel, remote_sel;
    logic force_en, cnt_clr;
    logic [19:0] thr [rostg_pkg::GROUPS];
    logic [1:0] dmode [rostg_pkg::GROUPS];
    logic [15:0] dly [rostg_pkg::GROUPS];
    logic [3:0] hist_sel;
    logic grp_hit;
    logic [2:0] grp_idx;

    assign grp_hit = (reg_addr[7:6] == rostg_pkg::GRP_PAGE);
    assign grp_idx = reg_addr[5:3];

    // static settings live outside the group table
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            src_sel <= rostg_pkg::SRC_COARSE;
            mag_sel <= rostg_pkg::MAG_RMS;
            force_sel <= rostg_pkg::FORCE_NORMAL;
            remote_sel <= rostg_pkg::REMOTE_OFF;
            force_en <= 1'b0;
            hist_sel <= 4'h0;
        end else if (reg_wr) begin
            if (reg_addr == rostg_pkg::REG_CTRL) begin
                src_sel <= reg_wdata[rostg_pkg::CTRL_SRC +: 2];
                mag_sel <= reg_wdata[rostg_pkg::CTRL_MAG +: 2];
                force_sel <= reg_wdata[rostg_pkg::CTRL_FORCE +: 2];
                remote_sel <= reg_wdata[rostg_pkg::CTRL_REMOTE +: 2];
                force_en <= reg_wdata[rostg_pkg::CTRL_FORCE_EN];
            end
            if (reg_addr == rostg_pkg::REG_HIST_SEL) begin
                hist_sel <= reg_wdata[3:0];
            end
        end
    end

    assign cnt_clr = reg_wr && (reg_addr == rostg_pkg::REG_CTRL)
        && reg_wdata[rostg_pkg::CTRL_CNT_CLR];

    // local writes win over a remote write in the same cycle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            for (int g = 0; g < rostg_pkg::GROUPS; g++) begin
                thr[g] <= rostg_pkg::THR_RST;
                dmode[g] <= rostg_pkg::DLY_INSTANT;
                dly[g] <= 16'h0;
            end
        end else if (reg_wr && grp_hit) begin
            if (!reg_addr[2]) begin
                thr[grp_idx] <= reg_wdata[19:0];
            end else begin
                dmode[grp_idx] <= reg_wdata[1:0];
                dly[grp_idx] <= reg_wdata[17:2];
            end
        end else if (remote_wr && remote_sel == rostg_pkg::REMOTE_ON) begin
            thr[grp_q] <= remote_thr;
        end
    end

    // ==========================================
    // magnitude selection and comparator
    logic [19:0] mag;
    logic above, below, pickup;
    logic [31:0] mag_x100, thr_x97;

    always_comb begin
        mag = coarse_rms;
        if (src_sel == rostg_pkg::SRC_CALC) begin
            mag = calc_rms;
        end else begin
            case (mag_sel)
                rostg_pkg::MAG_TRUE_RMS_WITH_HARMONICS: mag = (src_sel == rostg_pkg::SRC_SENS) ? sens_true_rms_with_harmonics
                    : coarse_true_rms_with_harmonics;
                rostg_pkg::MAG_PP: mag = (src_sel == rostg_pkg::SRC_SENS) ? sens_pp
                    : coarse_pp;
                default: mag = (src_sel == rostg_pkg::SRC_SENS) ? sens_rms : coarse_rms;
            endcase
        end
    end

    // the 97 percent reset ratio is kept exact by cross multiplication
    assign mag_x100 = 32'(mag) * 32'd100;
    assign thr_x97 = 32'(thr[grp_q]) * 32'(rostg_pkg::RESET_PCT);
    assign above = mag > thr[grp_q];
    assign below = mag_x100 < thr_x97;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pickup <= 1'b0;
        end else if (tick) begin
            if (!pickup && above) begin
                pickup <= 1'b1;
            end else if (pickup && below) begin
                pickup <= 1'b0;
            end
        end
    end

    // ==========================================
    // start, delay and trip
    logic raw_start, raw_trip, raw_block, force_act;
    logic [15:0] dly_cnt, next_dly_cnt;

    assign raw_start = pickup && !blk_q;
    assign raw_block = pickup && blk_q;
    assign force_act = force_en && (force_sel != rostg_pkg::FORCE_NORMAL);
    assign next_dly_cnt = (dly_cnt == 16'hffff) ? dly_cnt : dly_cnt + 16'h1;

    // inverse curve is not built; it runs on the fixed delay count
    always_comb begin
        case (dmode[grp_q])
            rostg_pkg::DLY_INSTANT: raw_trip = raw_start;
            default: raw_trip = raw_start && (next_dly_cnt >= dly[grp_q]);
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            dly_cnt <= 16'h0;
        end else if (tick) begin
            dly_cnt <= raw_start ? next_dly_cnt : 16'h0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            start_out <= 1'b0;
            trip_out <= 1'b0;
            blocked_out <= 1'b0;
        end else if (tick) begin
            if (force_act) begin
                start_out <= (force_sel != rostg_pkg::FORCE_BLOCKED);
                trip_out <= (force_sel == rostg_pkg::FORCE_TRIP);
                blocked_out <= (force_sel == rostg_pkg::FORCE_BLOCKED);
            end else begin
                start_out <= raw_start;
                trip_out <= raw_trip;
                blocked_out <= raw_block;
            end
        end
    end

    // ==========================================
    // event posting
    logic [2:0] prev_out, cur_out, rise, fall;
    logic [5:0] pend, set_ev, next_pend;
    logic edge_seen;
    logic [31:0] stamp_q;
    logic [19:0] mag_q;

    assign cur_out = {blocked_out, trip_out, start_out};
    assign rise = cur_out & ~prev_out;
    assign fall = prev_out & ~cur_out;
    assign set_ev = {fall[2], rise[2], fall[1], rise[1], fall[0], rise[0]};

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            prev_out <= 3'h0;
            edge_seen <= 1'b0;
        end else begin
            prev_out <= cur_out;
            edge_seen <= tick;
        end
    end

    // one stamp per program cycle, so events of one cycle share it
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            stamp_q <= 32'h0;
            mag_q <= 20'h0;
        end else if (tick) begin
            stamp_q <= ms_count;
            mag_q <= mag;
        end
    end

    // lowest pending code goes first; new edges win over the drain
    always_comb begin
        next_pend = pend;
        for (int i = 5; i >= 0; i--) begin
            if (pend[i]) begin
                next_pend = pend & ~(6'h1 << i);
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pend <= 6'h0;
            evt_valid <= 1'b0;
            evt_code <= 3'h0;
            evt_stamp <= 32'h0;
            evt_mag <= 20'h0;
        end else begin
            pend <= next_pend | set_ev;
            evt_valid <= |pend;
            evt_stamp <= stamp_q;
            evt_mag <= mag_q;
            evt_code <= 3'h0;
            for (int i = 5; i >= 0; i--) begin
                if (pend[i]) begin
                    evt_code <= 3'(i);
                end
            end
        end
    end

    // ==========================================
    // counters
    logic [15:0] cnt_start, cnt_trip, cnt_block;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_start <= 16'h0;
            cnt_trip <= 16'h0;
            cnt_block <= 16'h0;
        end else begin
            cnt_start <= (cnt_clr ? 16'h0 : cnt_start) + 16'(rise[0]);
            cnt_trip <= (cnt_clr ? 16'h0 : cnt_trip) + 16'(rise[1]);
            cnt_block <= (cnt_clr ? 16'h0 : cnt_block) + 16'(rise[2]);
        end
    end

    // ==========================================
    // pre-fault average and history
    logic [24:0] acc;
    logic [4:0] acc_n;
    logic [19:0] avg_last, avg_prev;
    logic [31:0] h_stamp [rostg_pkg::HIST_N];
    logic [2:0] h_code [rostg_pkg::HIST_N];
    logic [19:0] h_fault [rostg_pkg::HIST_N];
    logic [19:0] h_pre [rostg_pkg::HIST_N];
    logic [3:0] h_ptr, h_num;

    // block averages: the older finished window ends 20 to 39 ms back
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            acc <= 25'h0;
            acc_n <= 5'h0;
            avg_last <= 20'h0;
            avg_prev <= 20'h0;
        end else if (tick) begin
            if (acc_n == 5'(rostg_pkg::AVG_MS - 1)) begin
                avg_prev <= avg_last;
                avg_last <= 20'((acc + 25'(mag)) / 25'(rostg_pkg::AVG_MS));
                acc <= 25'h0;
                acc_n <= 5'h0;
            end else begin
                acc <= acc + 25'(mag);
                acc_n <= acc_n + 5'h1;
            end
        end
    end

    // one record per program cycle; trip outranks start and blocked
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            h_ptr <= 4'h0;
            h_num <= 4'h0;
            for (int k = 0; k < rostg_pkg::HIST_N; k++) begin
                h_stamp[k] <= 32'h0;
                h_code[k] <= 3'h0;
                h_fault[k] <= 20'h0;
                h_pre[k] <= 20'h0;
            end
        end else if (edge_seen && |rise) begin
            h_stamp[h_ptr] <= stamp_q;
            h_code[h_ptr] <= rise[1] ? rostg_pkg::EVT_TRIP_ON
                : rise[0] ? rostg_pkg::EVT_START_ON : rostg_pkg::EVT_BLOCK_ON;
            h_fault[h_ptr] <= mag_q;
            h_pre[h_ptr] <= avg_prev;
            h_ptr <= (h_ptr == 4'(rostg_pkg::HIST_N - 1)) ? 4'h0 : h_ptr + 4'h1;
            h_num <= (h_num == 4'(rostg_pkg::HIST_N)) ? h_num : h_num + 4'h1;
        end
    end

    // ==========================================
    // read port
    logic [3:0] hs;
    assign hs = (hist_sel < 4'(rostg_pkg::HIST_N)) ? hist_sel : 4'h0;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 32'h0;
        end else if (!reg_rd) begin
            reg_rdata <= 32'h0;
        end else if (grp_hit) begin
            reg_rdata <= reg_addr[2] ? {14'h0, dly[grp_idx], dmode[grp_idx]}
                : {12'h0, thr[grp_idx]};
        end else begin
            case (reg_addr)
                rostg_pkg::REG_CTRL: reg_rdata <= {23'h0, force_en, remote_sel,
                    force_sel, mag_sel, src_sel};
                rostg_pkg::REG_STATUS: reg_rdata <= {24'h0, grp_q, pickup, blk_q,
                    blocked_out, trip_out, start_out};
                rostg_pkg::REG_CNT_START: reg_rdata <= {16'h0, cnt_start};
                rostg_pkg::REG_CNT_TRIP: reg_rdata <= {16'h0, cnt_trip};
                rostg_pkg::REG_CNT_BLOCK: reg_rdata <= {16'h0, cnt_block};
                rostg_pkg::REG_HIST_SEL: reg_rdata <= {28'h0, hist_sel};
                rostg_pkg::REG_HIST_STAMP: reg_rdata <= h_stamp[hs];
                rostg_pkg::REG_HIST_INFO: reg_rdata <= {21'h0, h_ptr, h_num, h_code[hs]};
                rostg_pkg::REG_HIST_FAULT: reg_rdata <= {12'h0, h_fault[hs]};
                rostg_pkg::REG_HIST_PRE: reg_rdata <= {12'h0, h_pre[hs]};
                rostg_pkg::REG_TIME: reg_rdata <= ms_count;
                default: reg_rdata <= 32'h0;
            endcase
        end
    end

    // ==========================================
    // checks
    property p_inst_trip;
        @(posedge core_clk) disable iff (!nrst)
        (!force_act && dmode[grp_q] == rostg_pkg::DLY_INSTANT && tick)
            |=> (trip_out == start_out);
    endproperty
    a_inst_trip: assert property (p_inst_trip) else $error("instant trip not with start");

    property p_start_gate;
        @(posedge core_clk) disable iff (!nrst)
        $rose(start_out) && !$past(force_act) |-> $past(pickup) && !$past(blk_q);
    endproperty
    a_start_gate: assert property (p_start_gate) else $error("start without clean pick-up");

    property p_blocked;
        @(posedge core_clk) disable iff (!nrst)
        (tick && !force_act && pickup && blk_q) |=> blocked_out && !start_out;
    endproperty
    a_blocked: assert property (p_blocked) else $error("blocked pick-up not held off");

    property p_pickup;
        @(posedge core_clk) disable iff (!nrst)
        $rose(pickup) |-> $past(above);
    endproperty
    a_pickup: assert property (p_pickup) else $error("pick-up without overcurrent");

    property p_release;
        @(posedge core_clk) disable iff (!nrst)
        $fell(pickup) |-> $past(below);
    endproperty
    a_release: assert property (p_release) else $error("release above reset ratio");

    property p_ms_step;
        @(posedge core_clk) disable iff (!nrst)
        tick |=> ms_count == $past(ms_count) + 32'h1;
    endproperty
    a_ms_step: assert property (p_ms_step) else $error("stamp not one ms step");

    property p_evt_post;
        @(posedge core_clk) disable iff (!nrst)
        $rose(start_out) |-> ##[2:7] (evt_valid && evt_code == rostg_pkg::EVT_START_ON);
    endproperty
    a_evt_post: assert property (p_evt_post) else $error("start on event missing");

    property p_same_stamp;
        @(posedge core_clk) disable iff (!nrst)
        evt_valid && $past(evt_valid) |-> evt_stamp == $past(evt_stamp);
    endproperty
    a_same_stamp: assert property (p_same_stamp) else $error("burst stamps differ");

    property p_cnt;
        @(posedge core_clk) disable iff (!nrst)
        rise[0] && !cnt_clr |=> cnt_start == $past(cnt_start) + 16'h1;
    endproperty
    a_cnt: assert property (p_cnt) else $error("start counter missed");
endmodule
